// *** rtl/aux_pin_port.v ***
`timescale 1ns/1ps
`include "aux_pin_port_map.vh"

// Behaviour
// - control bits 6 to 0 and drive levels change only while the global unlock bit is set; the unlock bit itself is always writable.
// - control bits 6, 5, 4 turn pins 2, 1, 0 from push-pull into open-drain outputs.
// - control bits 3 to 0 make pins 3 to 0 inputs when clear and outputs when set.
// - drive-level bits 3 to 0 set the pin levels, the upper four bits read as zero.
// - read-back bits 3 to 0 show the present pin levels and cannot be written.
// - after reset the control register is zero: all inputs, push-pull, locked.
// - with start enabled pin 3 is the start input, others outputs, drive levels not writable, read-back held.
module aux_pin_port #(
   parameter PIN_COUNT = 4
) (
   // clock, reset, enable
   input  wire                 clk_i,
   input  wire                 reset_n_i,
   input  wire                 ce_i,
   // register port from the serial control logic
   input  wire [7:0]           reg_addr_i,
   input  wire                 reg_wr_en_i,
   input  wire [7:0]           reg_wr_data_i,
   input  wire                 reg_rd_en_i,
   output reg  [7:0]           reg_rd_data_o,
   output reg                  reg_rd_valid_o,
   // start function
   input  wire                 start_enable_i,
   output wire                 start_level_o,
   // pins
   input  wire [PIN_COUNT-1:0] aux_pin_i,
   output wire [PIN_COUNT-1:0] aux_pin_o,
   output wire [PIN_COUNT-1:0] aux_pin_oe_o
);

   // register state
   reg  [7:0]           pin_port_control_reg;
   reg  [7:0]           pin_port_control_next;
   reg  [3:0]           pin_drive_levels_reg;
   reg  [3:0]           pin_drive_levels_next;
   reg  [3:0]           pin_sampled_levels_reg;
   reg  [3:0]           pin_sampled_levels_next;
   reg  [7:0]           rd_data_next;

   // decoded fields
   wire                 port_global_unlock;
   wire [3:0]           pin_direction;
   wire [3:0]           pin_open_drain;
   wire [PIN_COUNT-1:0] pin_synced;
   reg  [3:0]           eff_direction;
   reg  [3:0]           pin_out_level;
   reg  [3:0]           pin_enable;
   integer              i;

   // write strobes and drive write value
   wire                 ctrl_wr_hit;
   wire                 drive_wr_hit;
   wire                 drive_wr_allowed;
   wire [3:0]           drive_wr_value;

   // reset values cut to the stored widths
   localparam [7:0]     CONTROL_RESET_FULL = `PIN_PORT_CONTROL_RESET;
   localparam [7:0]     DRIVE_RESET_FULL   = `PIN_DRIVE_LEVELS_RESET;
   localparam [7:0]     SAMPLED_RESET_FULL = `PIN_SAMPLED_LEVELS_RESET;

   // write strobe decode
   function hit;
      input [7:0] addr;
      input [7:0] offset;
      input       strobe;
      begin
         hit = strobe && (addr == offset);
      end
   endfunction

   // pad a four-bit pin field into a register byte
   function [7:0] pin_field_byte;
      input [3:0] field;
      begin
         pin_field_byte = {4'h0, field};
      end
   endfunction

   // output driver enable of one pin
   function stage_enable;
      input open_drain;
      input direction;
      input level;
      begin
         if (open_drain) begin
            stage_enable = direction & ~level;
         end else begin
            stage_enable = direction;
         end
      end
   endfunction

   // level presented by one pin driver
   function stage_level;
      input open_drain;
      input level;
      begin
         if (open_drain) begin
            stage_level = 1'b0;
         end else begin
            stage_level = level;
         end
      end
   endfunction

   assign port_global_unlock = pin_port_control_reg[`PORT_GLOBAL_UNLOCK_BIT];
   assign pin_direction = pin_port_control_reg[`PIN_DIRECTION_MSB:`PIN_DIRECTION_LSB];
   assign pin_open_drain = {1'b0,
                            pin_port_control_reg[`PIN2_OPEN_DRAIN_BIT],
                            pin_port_control_reg[`PIN1_OPEN_DRAIN_BIT],
                            pin_port_control_reg[`PIN0_OPEN_DRAIN_BIT]};

   // pin input synchroniser
   pin_sync2 #(
      .WIDTH (PIN_COUNT)
   ) u_pin_sync (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .ce_i      (ce_i),
      .async_i   (aux_pin_i),
      .sync_o    (pin_synced)
   );

   // write strobes
   assign ctrl_wr_hit      = hit(reg_addr_i, `PIN_PORT_CONTROL_OFFSET, reg_wr_en_i);
   assign drive_wr_hit     = hit(reg_addr_i, `PIN_DRIVE_LEVELS_OFFSET, reg_wr_en_i);
   assign drive_wr_allowed = drive_wr_hit && port_global_unlock
                             && !start_enable_i;
   assign drive_wr_value   = reg_wr_data_i[`PIN_LEVEL_MSB:`PIN_LEVEL_LSB];

   // control register next value
   always @* begin
      pin_port_control_next = pin_port_control_reg;
      if (ctrl_wr_hit) begin
         pin_port_control_next[`PORT_GLOBAL_UNLOCK_BIT] =
            reg_wr_data_i[`PORT_GLOBAL_UNLOCK_BIT];
         if (port_global_unlock) begin
            pin_port_control_next[6:0] = reg_wr_data_i[6:0];
         end
      end
   end

   // drive level next value
   always @* begin
      pin_drive_levels_next = pin_drive_levels_reg;
      if (drive_wr_allowed) begin
         pin_drive_levels_next = drive_wr_value;
      end
   end

   // read-back next value, held while start function owns the pins
   always @* begin
      pin_sampled_levels_next = pin_sampled_levels_reg;
      if (!start_enable_i) begin
         pin_sampled_levels_next = pin_synced[3:0];
      end
   end

   // read data mux
   always @* begin
      rd_data_next = `UNMAPPED_READ_VALUE;
      case (reg_addr_i)
         `PIN_PORT_CONTROL_OFFSET: begin
            rd_data_next = pin_port_control_reg;
         end
         `PIN_DRIVE_LEVELS_OFFSET: begin
            rd_data_next = pin_field_byte(pin_drive_levels_reg);
         end
         `PIN_SAMPLED_LEVELS_OFFSET: begin
            rd_data_next = pin_field_byte(pin_sampled_levels_reg);
         end
         default: begin
            rd_data_next = `UNMAPPED_READ_VALUE;
         end
      endcase
   end

   // register state
   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_port_control_reg   <= CONTROL_RESET_FULL;
         pin_drive_levels_reg   <= DRIVE_RESET_FULL[`PIN_LEVEL_MSB:`PIN_LEVEL_LSB];
         pin_sampled_levels_reg <= SAMPLED_RESET_FULL[`PIN_LEVEL_MSB:`PIN_LEVEL_LSB];
         reg_rd_data_o          <= 8'h00;
         reg_rd_valid_o         <= 1'b0;
      end else if (ce_i) begin
         pin_port_control_reg   <= pin_port_control_next;
         pin_drive_levels_reg   <= pin_drive_levels_next;
         pin_sampled_levels_reg <= pin_sampled_levels_next;
         reg_rd_valid_o         <= reg_rd_en_i;
         if (reg_rd_en_i) begin
            reg_rd_data_o <= rd_data_next;
         end
      end
   end

   // effective direction
   always @* begin
      eff_direction = pin_direction;
      if (start_enable_i) begin
         eff_direction = 4'hf;
         eff_direction[`START_PIN_INDEX] = 1'b0;
      end
   end

   // pin drive per pin
   always @* begin
      pin_out_level = 4'h0;
      pin_enable    = 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
         pin_out_level[i] = stage_level(pin_open_drain[i], pin_drive_levels_reg[i]);
         pin_enable[i]    = stage_enable(pin_open_drain[i], eff_direction[i],
                                         pin_drive_levels_reg[i]);
      end
   end

   assign aux_pin_o     = pin_out_level;
   assign aux_pin_oe_o  = pin_enable;
   assign start_level_o = start_enable_i ? pin_synced[`START_PIN_INDEX] : 1'b1;

endmodule

// *** pkg/aux_pin_port_map.vh ***
`ifndef AUX_PIN_PORT_MAP_VH
`define AUX_PIN_PORT_MAP_VH

// register offsets
`define PIN_PORT_CONTROL_OFFSET   8'h1e
`define PIN_DRIVE_LEVELS_OFFSET   8'h1f
`define PIN_SAMPLED_LEVELS_OFFSET 8'h20

// reset values and unmapped read value
`define PIN_PORT_CONTROL_RESET    8'h00
`define PIN_DRIVE_LEVELS_RESET    8'h00
`define PIN_SAMPLED_LEVELS_RESET  8'h00
`define UNMAPPED_READ_VALUE       8'h00

// control register fields
`define PORT_GLOBAL_UNLOCK_BIT    7
`define PIN2_OPEN_DRAIN_BIT       6
`define PIN1_OPEN_DRAIN_BIT       5
`define PIN0_OPEN_DRAIN_BIT       4
`define PIN_DIRECTION_MSB         3
`define PIN_DIRECTION_LSB         0

// drive and sampled level fields
`define PIN_LEVEL_MSB             3
`define PIN_LEVEL_LSB             0

// start function pin
`define START_PIN_INDEX           3

`endif

// *** rtl/pin_sync2.v ***
`timescale 1ns/1ps

// two-stage synchroniser, one per bit
module pin_sync2 #(
   parameter WIDTH = 4
) (
   // clock and reset
   input  wire             clk_i,
   input  wire             reset_n_i,
   input  wire             ce_i,
   // data
   input  wire [WIDTH-1:0] async_i,
   output wire [WIDTH-1:0] sync_o
);

   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;

   always @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stage1_reg <= {WIDTH{1'b0}};
         stage2_reg <= {WIDTH{1'b0}};
      end else if (ce_i) begin
         stage1_reg <= async_i;
         stage2_reg <= stage1_reg;
      end
   end

   assign sync_o = stage2_reg;

endmodule

// *** tb/aux_pin_port_checker.sv ***
`timescale 1ns/1ps
module aux_pin_port_checker (
   input logic       clk_i,
   input logic       reset_n_i,
   input logic       ce_i,
   input logic [7:0] reg_addr_i,
   input logic       reg_wr_en_i,
   input logic       reg_rd_en_i,
   input logic [7:0] reg_rd_data_o,
   input logic       reg_rd_valid_o,
   input logic       start_enable_i,
   input logic       start_level_o,
   input logic [3:0] aux_pin_i,
   input logic [3:0] aux_pin_o,
   input logic [3:0] aux_pin_oe_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   chk_rd_answer: assert property (ce_i && reg_rd_en_i |=> reg_rd_valid_o)
      else $error("read not answered");
   chk_rd_quiet: assert property (ce_i && !reg_rd_en_i |=> !reg_rd_valid_o)
      else $error("stray read answer");
   chk_upper_zero: assert property (ce_i && reg_rd_en_i && reg_addr_i != 8'h1e
      |=> reg_rd_data_o[7:4] == 4'h0) else $error("upper bits set");
   chk_read_sync: assert property ((ce_i && !start_enable_i && $stable(aux_pin_i))[*6]
      ##0 (reg_rd_en_i && reg_addr_i == 8'h20) |=> reg_rd_data_o == {4'h0, $past(aux_pin_i)})
      else $error("read-back wrong");
   chk_start_pin3: assert property (start_enable_i |-> !aux_pin_oe_o[3])
      else $error("pin3 driven in start mode");
   chk_start_idle: assert property (!start_enable_i |-> start_level_o)
      else $error("start level low while off");
   chk_start_lock: assert property (ce_i && reg_wr_en_i && reg_addr_i == 8'h1f
      && start_enable_i ##1 start_enable_i |-> $stable(aux_pin_o)) else $error("drive changed");
   chk_reset_clear: assert property ($rose(reset_n_i) && !start_enable_i
      |-> aux_pin_oe_o == 4'h0) else $error("outputs after reset");
endmodule
bind aux_pin_port aux_pin_port_checker u_aux_pin_port_checker (.*);

// *** tb/board_pins.sv ***
`timescale 1ns/1ps
module board_pins (
   input  logic [3:0] dut_out_i,
   input  logic [3:0] dut_oe_i,
   input  logic [3:0] ext_en_i,
   input  logic [3:0] ext_val_i,
   output logic [3:0] level_o
);
   // pull-up on every pin when nobody drives
   assign level_o = (dut_oe_i & dut_out_i) | (~dut_oe_i & ~ext_en_i)
                  | (~dut_oe_i & ext_en_i & ext_val_i);
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   logic       clk_i = 1'b0, reset_n_i = 1'b0, wr = 1'b0, rd_en = 1'b0, st = 1'b0, vld, st_lv;
   logic       ce = 1'b1;
   logic [7:0] addr = 8'h00, wd = 8'h00, rdd, q;
   logic [3:0] po, oe, lv, ext_en = 4'h0, ext_v = 4'h0;
   int         bad_count = 0, n_checks = 0;
   logic [39:0] rows [10] = '{40'h1e0f1e000f, 40'h1f0f1f000f, 40'h1e801e800f, 40'h1e8f2000f0,
      40'h1ff51f05f5, 40'h1eff2005a5, 40'h1f0a200ada, 40'h20ff200ada, 40'h1e701e700f,
      40'h1e0f21000f};
   always #2.5 clk_i = ~clk_i;
   aux_pin_port u_aux_pin_port (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce),
      .reg_addr_i(addr), .reg_wr_en_i(wr), .reg_wr_data_i(wd), .reg_rd_en_i(rd_en),
      .reg_rd_data_o(rdd), .reg_rd_valid_o(vld), .start_enable_i(st), .start_level_o(st_lv),
      .aux_pin_i(lv), .aux_pin_o(po), .aux_pin_oe_o(oe));
   board_pins u_board_pins (.dut_out_i(po), .dut_oe_i(oe), .ext_en_i(ext_en),
      .ext_val_i(ext_v), .level_o(lv));
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      addr = a;
      wd = d;
      wr = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
   endtask
   task rd_reg(input logic [7:0] a);
      @(negedge clk_i);
      addr = a;
      rd_en = 1'b1;
      @(negedge clk_i);
      rd_en = 1'b0;
      q = rdd;
      chk({7'h00, vld}, 8'h01);
   endtask
   task reset_check;
      rd_reg(8'h1e);
      chk(q, 8'h00);
      chk({oe, lv}, 8'h0f);
      $display("reset test done");
   endtask
   task finish_test;
      $display("checks=%0d mismatches=%0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #20000;
      bad_count++;
      finish_test;
   end
   initial begin
      repeat (16) @(negedge clk_i);
      reset_n_i = 1'b1;
      reset_check;
      for (int i = 0; i < 10; i++) begin
         wr_reg(rows[i][39:32], rows[i][31:24]);
         repeat (5) @(negedge clk_i);
         rd_reg(rows[i][23:16]);
         chk(q, rows[i][15:8]);
         chk({oe, lv}, rows[i][7:0]);
         $display("row %0d done", i);
      end
      // start mode: unlocked, board drives pin 3 low
      wr_reg(8'h1e, 8'h80);
      ext_en = 4'h8;
      st = 1'b1;
      wr_reg(8'h1f, 8'h0f);
      repeat (5) @(negedge clk_i);
      rd_reg(8'h20);
      chk(q, 8'h0f);
      rd_reg(8'h1f);
      chk(q, 8'h0a);
      chk({oe, lv}, 8'h52);
      chk({4'h0, po}, 8'h08);
      chk({7'h00, st_lv}, 8'h00);
      ext_v = 4'h8;
      repeat (4) @(negedge clk_i);
      chk({7'h00, st_lv}, 8'h01);
      $display("start test done");
      reset_n_i = 1'b0;
      st = 1'b0;
      ext_en = 4'h0;
      repeat (2) @(negedge clk_i);
      reset_n_i = 1'b1;
      reset_check;
      // clock enable low: write must not land
      ce = 1'b0;
      wr_reg(8'h1e, 8'h80);
      ce = 1'b1;
      rd_reg(8'h1e);
      chk(q, 8'h00);
      $display("enable test done");
      finish_test;
   end
endmodule
